// >>> core/ppp_pkg.sv
// constants, types and states of the parallel programming port
// assumes a single 40 MHz clock; pin timing is handled by the main module
package ppp_pkg;

  // =========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PROG_TIME_NS  = 1000;
  localparam logic [7:0]  PROG_CYC      =
    8'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // =========================================================
  // action select and command codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
  localparam logic [7:0] CMD_RD_SIG     = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;

  // =========================================================
  // memory geometry
  localparam int unsigned FLASH_WORDS = 512;
  localparam int unsigned FLASH_PAGE  = 32;
  localparam int unsigned EE_BYTES    = 256;
  localparam int unsigned EE_PAGE     = 4;
  localparam logic [4:0]  FLASH_LAST  = 5'h1f;
  localparam logic [4:0]  EE_LAST     = 5'h03;
  localparam int unsigned FIFO_DEPTH  = 8;

  // =========================================================
  // reset values of fuses, locks and identification bytes
  localparam logic [7:0] FUSE_LO_RST  = 8'hff;
  localparam logic [7:0] FUSE_HI_RST  = 8'hff;
  localparam logic [7:0] FUSE_EXT_RST = 8'hff;
  localparam logic [7:0] LOCK_RST     = 8'hff;
  localparam logic [7:0] LOCK_UNUSED  = 8'hc0;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // identification values below are arbitrary
  localparam logic [7:0] SIG_BYTE0 = 8'h5a;
  localparam logic [7:0] SIG_BYTE1 = 8'h3c;
  localparam logic [7:0] SIG_BYTE2 = 8'h01;
  localparam logic [7:0] CAL_BYTE  = 8'h80;

  // =========================================================
  // types
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DRAIN = 4'b0010,
    ST_COPY  = 4'b0100,
    ST_WAIT  = 4'b1000
  } ppp_state_t;

  typedef struct packed {
    logic [4:0]  idx;
    logic [15:0] word;
  } ppp_entry_t;

endpackage

// >>> core/ppp_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes one clock; in_ready low means a push is not taken
`timescale 1ns/1ps
`default_nettype none
module ppp_fifo #(
  parameter int unsigned WIDTH = 21,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output var  logic             o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output var  logic             o_out_valid,
  input  wire logic             i_out_ready,
  output var  logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ppp_fifo_state_t;

  ppp_fifo_state_t  q;
  ppp_fifo_state_t  next_q;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full        = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign empty       = (q.wp == q.rp);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[q.rp[AW-1:0]];
  assign push        = i_in_valid && !full;
  assign pop         = i_out_ready && !empty;

  always_comb begin
    next_q = q;
    if (push) begin
      next_q.wp = q.wp + 1'b1;
    end
    if (pop) begin
      next_q.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[q.wp[AW-1:0]] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

// >>> core/ppp_port.sv
// device side of the high-voltage parallel programming port
// assumes all pins except the asynchronous reset i_rst_n are synchronous to i_clk; the data bus is split into in, out, enable
`timescale 1ns/1ps
`default_nettype none
module ppp_port
  import ppp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_crystal_input_pulse,
  input  wire logic       i_action_select_hi,
  input  wire logic       i_action_select_lo,
  input  wire logic       i_byte_select_low,
  input  wire logic       i_byte_select_second,
  input  wire logic       i_page_latch_strobe,
  input  wire logic       i_write_n,
  input  wire logic       i_output_enable_n,
  input  wire logic [7:0] i_data,
  output var  logic [7:0] o_data,
  output var  logic       o_data_oe_n,
  output var  logic       o_ready_busy,
  output var  logic       o_load_ready
);
  // =========================================================
  // state
  typedef struct packed {
    ppp_state_t  st;
    logic [7:0]  cmd;
    logic [7:0]  addr_hi;
    logic [7:0]  addr_lo;
    logic [7:0]  dat_lo;
    logic [7:0]  dat_hi;
    logic [7:0]  fuse_lo;
    logic [7:0]  fuse_hi;
    logic [7:0]  fuse_ext;
    logic [7:0]  lock;
    logic [31:0] pvalid;
    logic [4:0]  cnt;
    logic [7:0]  tmr;
    logic        is_ee;
    logic        xtal_q;
    logic        wr_q;
    logic        pl_q;
    logic        rdy;
    logic [7:0]  dout;
    logic        doe_n;
    logic        lready;
  } ppp_port_state_t;

  ppp_port_state_t q;
  ppp_port_state_t next_q;

  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0]  ee_mem    [EE_BYTES];
  logic [15:0] pbuf      [FLASH_PAGE];

  logic [1:0]  act;
  logic        xtal_rise;
  logic        wr_fall;
  logic        pl_rise;
  logic        idle;
  logic        erase_go;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_pop;
  ppp_entry_t  fifo_in;
  ppp_entry_t  fifo_out;
  logic [8:0]  flash_idx;
  logic [15:0] rd_word;
  logic [7:0]  rd_byte;
  logic [7:0]  rd_mux;
  logic [4:0]  copy_last;
  logic        copy_wr;

  // =========================================================
  // pin edges and decode
  assign act       = {i_action_select_hi, i_action_select_lo};
  assign xtal_rise = i_crystal_input_pulse && !q.xtal_q;
  assign wr_fall   = !i_write_n && q.wr_q;
  assign pl_rise   = i_page_latch_strobe && !q.pl_q;
  assign idle      = (q.st == ST_IDLE);
  assign erase_go  = idle && wr_fall && (q.cmd == CMD_CHIP_ERASE);
  assign flash_idx = {q.addr_hi[0], q.addr_lo};
  assign rd_word   = flash_mem[flash_idx];
  assign rd_byte   = ee_mem[q.addr_lo];
  assign copy_last = q.is_ee ? EE_LAST : FLASH_LAST;
  assign copy_wr   = (q.st == ST_COPY) && q.pvalid[q.cnt];

  // =========================================================
  // page load path
  assign fifo_in.idx   = (q.cmd == CMD_WR_EEPROM) ? {3'h0, q.addr_lo[1:0]}
                                                  : q.addr_lo[4:0];
  assign fifo_in.word  = {q.dat_hi, q.dat_lo};
  assign fifo_in_valid = pl_rise && i_byte_select_low && idle;
  assign fifo_pop      = fifo_out_valid && (idle || (q.st == ST_DRAIN));

  ppp_fifo #(
    .WIDTH ($bits(ppp_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_out)
  );

  // =========================================================
  // read multiplexer
  always_comb begin
    rd_mux = ERASED_BYTE;
    unique case (q.cmd)
      CMD_RD_FLASH: begin
        rd_mux = i_byte_select_low ? rd_word[15:8] : rd_word[7:0];
      end
      CMD_RD_EEPROM: begin
        if (!i_byte_select_low) begin
          rd_mux = rd_byte;
        end
      end
      CMD_RD_FUSE: begin
        unique case ({i_byte_select_second, i_byte_select_low})
          2'h0: rd_mux = q.fuse_lo;
          2'h3: rd_mux = q.fuse_hi;
          2'h2: rd_mux = q.fuse_ext;
          2'h1: rd_mux = q.lock | LOCK_UNUSED;
        endcase
      end
      CMD_RD_SIG: begin
        if (!i_byte_select_low) begin
          unique case (q.addr_lo)
            8'h00:   rd_mux = SIG_BYTE0;
            8'h01:   rd_mux = SIG_BYTE1;
            8'h02:   rd_mux = SIG_BYTE2;
            default: rd_mux = ERASED_BYTE;
          endcase
        end else if (q.addr_lo == 8'h00) begin
          rd_mux = CAL_BYTE;
        end
      end
      default: rd_mux = ERASED_BYTE;
    endcase
  end

  // =========================================================
  // control
  always_comb begin
    next_q        = q;
    next_q.xtal_q = i_crystal_input_pulse;
    next_q.wr_q   = i_write_n;
    next_q.pl_q   = i_page_latch_strobe;

    if (xtal_rise) begin
      unique case (act)
        ACT_ADDR: begin
          if (i_byte_select_low) begin
            next_q.addr_hi = i_data;
          end else begin
            next_q.addr_lo = i_data;
          end
        end
        ACT_DATA: begin
          if (i_byte_select_low) begin
            next_q.dat_hi = i_data;
          end else begin
            next_q.dat_lo = i_data;
          end
        end
        ACT_CMD: begin
          if (idle) begin
            next_q.cmd = i_data;
            if (i_data == CMD_NOP) begin
              next_q.pvalid = '0;
            end
          end
        end
        ACT_IDLE: begin
        end
      endcase
    end

    if (fifo_pop) begin
      next_q.pvalid[fifo_out.idx] = 1'b1;
    end

    unique case (q.st)
      ST_IDLE: begin
        if (wr_fall) begin
          if (q.cmd == CMD_WR_FLASH) begin
            next_q.st    = ST_DRAIN;
            next_q.is_ee = 1'b0;
          end else if ((q.cmd == CMD_WR_EEPROM) && !i_byte_select_low) begin
            next_q.st    = ST_DRAIN;
            next_q.is_ee = 1'b1;
          end else if (q.cmd == CMD_WR_FUSE) begin
            next_q.st  = ST_WAIT;
            next_q.tmr = PROG_CYC;
            unique case ({i_byte_select_second, i_byte_select_low})
              2'h0: next_q.fuse_lo  = q.dat_lo;
              2'h1: next_q.fuse_hi  = q.dat_lo;
              2'h2: next_q.fuse_ext = q.dat_lo;
              2'h3: next_q.st       = ST_IDLE;
            endcase
          end else if (q.cmd == CMD_WR_LOCK) begin
            next_q.st   = ST_WAIT;
            next_q.tmr  = PROG_CYC;
            next_q.lock = q.lock & q.dat_lo;
            if (q.lock[1:0] == 2'h0) begin
              next_q.lock[5:2] = q.lock[5:2];
            end
          end else if (q.cmd == CMD_CHIP_ERASE) begin
            next_q.st   = ST_WAIT;
            next_q.tmr  = PROG_CYC;
            next_q.lock = LOCK_RST;
          end
        end
      end
      ST_DRAIN: begin
        if (!fifo_out_valid) begin
          next_q.st  = ST_COPY;
          next_q.cnt = '0;
        end
      end
      ST_COPY: begin
        next_q.cnt = q.cnt + 5'h01;
        if (q.cnt == copy_last) begin
          next_q.st     = ST_WAIT;
          next_q.tmr    = PROG_CYC;
          next_q.pvalid = '0;
        end
      end
      ST_WAIT: begin
        next_q.tmr = q.tmr - 8'h01;
        if (q.tmr == 8'h01) begin
          next_q.st = ST_IDLE;
        end
      end
    endcase

    next_q.rdy    = (next_q.st == ST_IDLE);
    next_q.doe_n  = i_output_enable_n;
    next_q.dout   = i_output_enable_n ? 8'h00 : rd_mux;
    next_q.lready = fifo_in_ready && (next_q.st == ST_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.fuse_lo  <= FUSE_LO_RST;
      q.fuse_hi  <= FUSE_HI_RST;
      q.fuse_ext <= FUSE_EXT_RST;
      q.lock     <= LOCK_RST;
      q.xtal_q   <= 1'b1;
      q.wr_q     <= 1'b1;
      q.pl_q     <= 1'b1;
      q.rdy      <= 1'b1;
      q.doe_n    <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // =========================================================
  // memories and page buffer
  always_ff @(posedge i_clk) begin
    if (fifo_pop) begin
      pbuf[fifo_out.idx] <= fifo_out.word;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < FLASH_WORDS; i++) begin
        flash_mem[i] <= ERASED_WORD;
      end
      for (int j = 0; j < EE_BYTES; j++) begin
        ee_mem[j] <= ERASED_BYTE;
      end
    end else if (copy_wr) begin
      if (q.is_ee) begin
        ee_mem[{q.addr_lo[7:2], q.cnt[1:0]}] <= pbuf[q.cnt][7:0];
      end else begin
        flash_mem[{flash_idx[8:5], q.cnt}] <= pbuf[q.cnt];
      end
    end
  end

  assign o_data       = q.dout;
  assign o_data_oe_n  = q.doe_n;
  assign o_ready_busy = q.rdy;
  assign o_load_ready = q.lready;

  // =========================================================
  // checks
  a_addr_high_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    xtal_rise && (act == ACT_ADDR) && i_byte_select_low |=> q.addr_hi == $past(i_data))
    else $error("address high byte not stored");

  a_busy_on_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    idle && wr_fall && (q.cmd == CMD_WR_FLASH) |=> !o_ready_busy [*2])
    else $error("flash page write did not show busy");

  a_nop_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    idle && xtal_rise && (act == ACT_CMD) && (i_data == CMD_NOP) && !fifo_pop
    |=> (q.cmd == CMD_NOP) && (q.pvalid == '0))
    else $error("no-operation command left write controls set");

  a_busy_ignores: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !idle && xtal_rise && (act == ACT_CMD) |=> $stable(q.cmd))
    else $error("command taken while busy");

  a_drive_only_oe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_data_oe_n |-> $past(!i_output_enable_n))
    else $error("data bus driven without output enable");

  a_lock_no_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.lock & ~$past(q.lock)) != 8'h00 |-> $past(erase_go))
    else $error("lock bit cleared without chip erase");

  a_boot_lock_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($past(q.lock[1:0]) == 2'h0) && !$past(erase_go) |-> $stable(q.lock[5:2]))
    else $error("boot lock bits changed in lock mode 3");

  a_fuse_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    idle && wr_fall && (q.cmd == CMD_WR_FUSE) && !i_byte_select_second && i_byte_select_low
    |=> (q.fuse_hi == $past(q.dat_lo)) && $stable(q.fuse_lo) && $stable(q.fuse_ext))
    else $error("fuse write hit the wrong byte");

  a_busy_bounded: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_ready_busy) |-> ##[1:120] o_ready_busy)
    else $error("busy did not end in time");

  a_read_flash_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.cmd == CMD_RD_FLASH) && !i_output_enable_n && !i_byte_select_low
    |=> o_data == $past(rd_word[7:0]))
    else $error("flash low byte not driven");
endmodule
`default_nettype wire

// >>> tb/ppp_prog.sv
// programmer model for the parallel programming pins
// assumes pins are sampled on rising i_clk; it drives 1 ns after that edge
`timescale 1ns/1ps
`default_nettype none
module ppp_prog
  import ppp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_dev_data,
  input  wire logic       i_dev_oe_n,
  input  wire logic       i_ready_busy,
  output var  logic       o_xtal,
  output var  logic       o_act_hi,
  output var  logic       o_act_lo,
  output var  logic       o_sel_lo,
  output var  logic       o_sel_second,
  output var  logic       o_page_latch,
  output var  logic       o_write_n,
  output var  logic       o_oe_n,
  output var  logic [7:0] o_data
);
  logic [7:0] last;

  initial begin
    {o_xtal, o_page_latch, o_sel_lo, o_sel_second} = 4'h0;
    {o_act_hi, o_act_lo, o_write_n, o_oe_n} = 4'hf;
    o_data = 8'h00;
    last = 8'h00;
  end

  // =========================================================
  // pin sequences
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask

  task automatic load(input logic [1:0] act, input logic sel, input logic [7:0] d);
    tick();
    {o_act_hi, o_act_lo} = act;
    o_sel_lo = sel;
    o_data = d;
    last = d;
    o_xtal = 1'b1;
    tick();
    o_xtal = 1'b0;
    tick();
  endtask

  task automatic latch();
    tick();
    o_sel_lo = 1'b1;
    o_page_latch = 1'b1;
    tick();
    o_page_latch = 1'b0;
    tick();
  endtask

  task automatic wr(input logic sel, input logic sel2);
    tick();
    o_sel_lo = sel;
    o_sel_second = sel2;
    o_write_n = 1'b0;
    tick();
    o_write_n = 1'b1;
    tick();
  endtask

  // programmer waits for ready before the next page
  task automatic wait_ready(output int n);
    n = 0;
    while (i_ready_busy !== 1'b1 && n < 1000) begin
      tick();
      n++;
    end
  endtask

  // bus released while reading: show a value unlike the last one
  task automatic read(input logic sel, input logic sel2, output logic [7:0] v,
                      output logic oe);
    tick();
    o_sel_lo = sel;
    o_sel_second = sel2;
    o_oe_n = 1'b0;
    o_data = ~last;
    tick();
    tick();
    v = i_dev_data;
    oe = i_dev_oe_n;
    o_oe_n = 1'b1;
    tick();
    tick();
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench of the parallel programming port
// assumes the programmer model drives every pin of the port except i_clk and i_rst_n, which this bench drives
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end
module tb_top
  import ppp_pkg::*;
;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] adr;
    logic       sel;
    logic       sel2;
    logic [7:0] exp;
  } ppp_row_t;

  logic       clk;
  logic       rst_n;
  logic       xtal, act_hi, act_lo, sel_lo, sel2, pl, wr_n, oe_n;
  logic [7:0] din, dout, v, a;
  logic       dev_oe_n, rdy, load_rdy, oe;
  int         n_errors, checks_done, cycles, n;
  ppp_row_t   rows [11];

  ppp_port DUT (
    .i_clk                (clk),
    .i_rst_n              (rst_n),
    .i_crystal_input_pulse(xtal),
    .i_action_select_hi   (act_hi),
    .i_action_select_lo   (act_lo),
    .i_byte_select_low    (sel_lo),
    .i_byte_select_second (sel2),
    .i_page_latch_strobe  (pl),
    .i_write_n            (wr_n),
    .i_output_enable_n    (oe_n),
    .i_data               (din),
    .o_data               (dout),
    .o_data_oe_n          (dev_oe_n),
    .o_ready_busy         (rdy),
    .o_load_ready         (load_rdy)
  );

  ppp_prog u_prog (
    .i_clk       (clk),
    .i_dev_data  (dout),
    .i_dev_oe_n  (dev_oe_n),
    .i_ready_busy(rdy),
    .o_xtal      (xtal),
    .o_act_hi    (act_hi),
    .o_act_lo    (act_lo),
    .o_sel_lo    (sel_lo),
    .o_sel_second(sel2),
    .o_page_latch(pl),
    .o_write_n   (wr_n),
    .o_oe_n      (oe_n),
    .o_data      (din)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // =========================================================
  // helpers
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] c);
    u_prog.load(ACT_CMD, 1'b0, c);
  endtask

  task automatic rd(input logic [7:0] ad, input logic s, input logic s2);
    u_prog.load(ACT_ADDR, 1'b0, ad);
    u_prog.read(s, s2, v, oe);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  // =========================================================
  // tests
  initial begin
    rows = '{
      '{CMD_RD_FUSE, 8'h00, 1'b0, 1'b0, FUSE_LO_RST},
      '{CMD_RD_FUSE, 8'h00, 1'b1, 1'b1, FUSE_HI_RST},
      '{CMD_RD_FUSE, 8'h00, 1'b0, 1'b1, FUSE_EXT_RST},
      '{CMD_RD_FUSE, 8'h00, 1'b1, 1'b0, LOCK_RST},
      '{CMD_RD_SIG, 8'h00, 1'b0, 1'b0, SIG_BYTE0},
      '{CMD_RD_SIG, 8'h01, 1'b0, 1'b0, SIG_BYTE1},
      '{CMD_RD_SIG, 8'h02, 1'b0, 1'b0, SIG_BYTE2},
      '{CMD_RD_SIG, 8'h03, 1'b0, 1'b0, 8'hff},
      '{CMD_RD_SIG, 8'h00, 1'b1, 1'b0, CAL_BYTE},
      '{CMD_RD_FLASH, 8'h00, 1'b0, 1'b0, ERASED_BYTE},
      '{CMD_RD_EEPROM, 8'h09, 1'b0, 1'b0, ERASED_BYTE}};
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK(rdy, 1'b1)
    `CHK(dev_oe_n, 1'b1)
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(load_rdy, 1'b1)
    $display("test reset done");
    foreach (rows[i]) begin
      cmd(rows[i].cmd);
      rd(rows[i].adr, rows[i].sel, rows[i].sel2);
      `CHK(v, rows[i].exp)
      `CHK(oe, 1'b0)
      `CHK(dev_oe_n, 1'b1)
    end
    $display("test reads done");
    cmd(CMD_WR_FUSE);
    u_prog.load(ACT_DATA, 1'b0, 8'h3c);
    u_prog.wr(1'b0, 1'b1);
    u_prog.wait_ready(n);
    `CHK(n + 1 >= PROG_CYC && n <= PROG_CYC, 1'b1)
    u_prog.load(ACT_DATA, 1'b0, 8'ha5);
    u_prog.wr(1'b1, 1'b0);
    `CHK(rdy, 1'b0)
    u_prog.wr(1'b0, 1'b0);
    cmd(CMD_RD_FUSE);
    u_prog.wait_ready(n);
    rd(8'h00, 1'b1, 1'b1);
    `CHK(v, 8'hff)
    cmd(CMD_RD_FUSE);
    rd(8'h00, 1'b1, 1'b1);
    `CHK(v, 8'ha5)
    rd(8'h00, 1'b0, 1'b1);
    `CHK(v, 8'h3c)
    rd(8'h00, 1'b0, 1'b0);
    `CHK(v, FUSE_LO_RST)
    $display("test fuse done");
    cmd(CMD_WR_FLASH);
    u_prog.load(ACT_ADDR, 1'b1, 8'h01);
    for (int p = 0; p < 2; p++) begin
      for (int w = 0; w < 2; w++) begin
        a = 8'(p * 32 + w * 31);
        u_prog.load(ACT_ADDR, 1'b0, a);
        u_prog.load(ACT_DATA, 1'b0, a ^ 8'h5a);
        u_prog.load(ACT_DATA, 1'b1, a ^ 8'h0f);
        u_prog.latch();
      end
      u_prog.wr(1'b0, 1'b0);
      `CHK(rdy, 1'b0)
      `CHK(load_rdy, 1'b0)
      u_prog.wait_ready(n);
      `CHK(rdy, 1'b1)
    end
    u_prog.load(ACT_ADDR, 1'b0, 8'h40);
    u_prog.load(ACT_DATA, 1'b0, 8'h00);
    u_prog.latch();
    cmd(CMD_NOP);
    cmd(CMD_WR_FLASH);
    u_prog.wr(1'b0, 1'b0);
    u_prog.wait_ready(n);
    cmd(CMD_RD_FLASH);
    for (int i = 0; i < 4; i++) begin
      a = 8'((i / 2) * 32 + (i % 2) * 31);
      rd(a, 1'b0, 1'b0);
      `CHK(v, a ^ 8'h5a)
      rd(a, 1'b1, 1'b0);
      `CHK(v, a ^ 8'h0f)
    end
    rd(8'h40, 1'b0, 1'b0);
    `CHK(v, ERASED_BYTE)
    u_prog.load(ACT_ADDR, 1'b1, 8'h00);
    rd(8'h00, 1'b0, 1'b0);
    `CHK(v, ERASED_BYTE)
    $display("test flash done");
    cmd(CMD_WR_EEPROM);
    u_prog.load(ACT_ADDR, 1'b1, 8'h00);
    for (int i = 4; i < 8; i++) begin
      u_prog.load(ACT_ADDR, 1'b0, 8'(i));
      u_prog.load(ACT_DATA, 1'b0, 8'(i * 3));
      u_prog.latch();
    end
    u_prog.wr(1'b0, 1'b0);
    `CHK(rdy, 1'b0)
    u_prog.wait_ready(n);
    cmd(CMD_RD_EEPROM);
    for (int i = 4; i < 8; i++) begin
      rd(8'(i), 1'b0, 1'b0);
      `CHK(v, 8'(i * 3))
    end
    $display("test eeprom done");
    cmd(CMD_WR_LOCK);
    u_prog.load(ACT_DATA, 1'b0, 8'hfc);
    u_prog.wr(1'b0, 1'b0);
    u_prog.wait_ready(n);
    u_prog.load(ACT_DATA, 1'b0, 8'hc3);
    u_prog.wr(1'b0, 1'b0);
    u_prog.wait_ready(n);
    u_prog.load(ACT_DATA, 1'b0, 8'hff);
    u_prog.wr(1'b0, 1'b0);
    u_prog.wait_ready(n);
    cmd(CMD_RD_FUSE);
    rd(8'h00, 1'b1, 1'b0);
    `CHK(v, 8'hfc)
    cmd(CMD_CHIP_ERASE);
    u_prog.wr(1'b0, 1'b0);
    u_prog.wait_ready(n);
    cmd(CMD_RD_FUSE);
    u_prog.load(ACT_IDLE, 1'b0, CMD_RD_SIG);
    rd(8'h00, 1'b1, 1'b0);
    `CHK(v, LOCK_RST)
    $display("test lock done");
    end_of_test();
  end
endmodule
`default_nettype wire
